/* File: hw/contact_mode_pkg.sv */
// shared constants and types for the contact speed / torque mode selector
package contact_mode_pkg;
   localparam int SPD_W           = 16;
   localparam int CLK_PERIOD_NS   = 25;
   // contact sampling period; must stay well inside the latency bound
   localparam int SAMPLE_TIME_US  = 2000;
   localparam int SAMPLE_CYC      = SAMPLE_TIME_US * 1000 / CLK_PERIOD_NS;
   // longest allowed contact read latency, rounded down
   localparam int MAX_LATENCY_US  = 6000;
   localparam int MAX_LATENCY_CYC = MAX_LATENCY_US * 1000 / CLK_PERIOD_NS;
   // soft-start step interval
   localparam int RAMP_TIME_US    = 1000;
   localparam int RAMP_CYC        = RAMP_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int CNT_W           = $clog2(MAX_LATENCY_CYC + 1);

   // field positions in the function switch words
   localparam int BIT_MODE_A      = 10;
   localparam int BIT_MODE_B      = 11;
   localparam int BIT_PULSE_F     = 15;
   localparam int BIT_CONTACT_SPD = 2;
   localparam int BIT_TREF_LIMIT  = 15;

   localparam logic [15:0] WORD_RESET = 16'h0000;
   // synchroniser reset levels: contacts idle high (OFF), pulse pin idles low
   localparam logic [3:0]  PIN_IDLE   = 4'h7;

   typedef enum logic [3:0] {
      MODE_STOP_ZERO    = 4'h0,
      MODE_STOP_CLAMP   = 4'h1,
      MODE_ANALOG       = 4'h2,
      MODE_ANALOG_CLAMP = 4'h3,
      MODE_PRESET       = 4'h4,
      MODE_PULSE        = 4'h5,
      MODE_SPEED_STD    = 4'h6,
      MODE_TORQUE_I     = 4'h7,
      MODE_TORQUE_II_T  = 4'h8,
      MODE_TORQUE_II_S  = 4'h9
   } mode_t;

   typedef enum logic [1:0] {
      TREF_UNUSED  = 2'h0,
      TREF_TORQUE  = 2'h1,
      TREF_FEEDFWD = 2'h2,
      TREF_LIMIT   = 2'h3
   } tref_role_t;

   typedef struct packed {
      logic        isPosition;
      logic [15:0] functionSwitchWordB;
      logic [15:0] functionSwitchWordA;
   } cfg_t;

   typedef struct packed {
      logic [15:0] presetSpeedOne;
      logic [15:0] presetSpeedTwo;
      logic [15:0] presetSpeedThree;
      logic [15:0] maxSpeedLimitSetting;
      logic [15:0] accelStep;
      logic [15:0] decelStep;
   } speeds_t;
endpackage

/* File: hw/contact_speed_torque_mode_select.sv */
// contact input speed selection and torque control mode decoder
// Summary of operation
// [R1] contact speed on: first off/second on speed one, both speed two, first only three
// [R2] speed type stop row: mode bits pick zero stop, clamp stop, analog, analog clamp
// [R3] position type stop row: bit F zero stops, one accepts pulse reference
// [R4] contact speed on: direction contact on means reverse, off means forward
// [R5] inputs irrelevant to the selected row never affect the result
// [R6] contact speed on disables the reference pulse inhibit function
// [R7] contact speed off: select contacts become forward and reverse torque limits
// [R8] contact speed off: direction contact gives proportional, clamp or changeover
// [R9] position type soft start only in contact speed, never with pulses
// [R10] preset to pulse while running drops pulses until positioning completes
// [R11] host sends pulses only after seeing positioning complete
// [R12] select contacts read within 6 ms, independent of soft start
// [R13] torque control one: torque input, no direction or speed input, max limit
// [R14] torque control two: contact open torque, contact at 0 V speed
// [R15] torque control two: torque input is command, feed-forward or limit
// [R16] torque control two torque mode: positive speed reference limits both directions
// [R17] overspeed adds negative torque proportional to the excess
// [R18] contact speed on: direction contact only sets rotation direction
// [R19] internal speed reference ramps by accel and decel steps
// [R20] product type input picks speed or position decoding
`timescale 1ns/100ps
module contact_speed_torque_mode_select #(
   parameter int SAMPLE_CYC = contact_mode_pkg::SAMPLE_CYC,
   parameter int RAMP_CYC   = contact_mode_pkg::RAMP_CYC
) (
   // clock and reset
   input  wire logic                           ref_clk,
   input  wire logic                           rst_n,
   // static configuration
   input  wire contact_mode_pkg::cfg_t         cfg,
   input  wire contact_mode_pkg::speeds_t      spd,
   input  wire logic [3:0]                     feedbackShift,
   // contact pins, active low, then the reference pulse pin, active high
   input  wire logic                           directionChangeoverContact_n,
   input  wire logic                           speedSelectFirst_n,
   input  wire logic                           speedSelectSecond_n,
   input  wire logic                           refPulsePin,
   // references and feedback on this clock
   input  wire logic signed [15:0]             speedRefIn,
   input  wire logic signed [15:0]             torqueRefIn,
   input  wire logic signed [15:0]             actualSpeed,
   input  wire logic                           positionDone,
   // decoded state
   output contact_mode_pkg::mode_t             activeMode,
   output contact_mode_pkg::tref_role_t        torqueRefRole,
   output logic                                reverseRotation,
   output logic                                propControl,
   output logic                                zeroClamp,
   output logic                                torqueLimitFwd,
   output logic                                torqueLimitRev,
   output logic                                pulseInhibitEnable,
   output logic                                softStartOn,
   // commands
   output logic signed [15:0]                  speedCmd,
   output logic signed [15:0]                  torqueCmd,
   output logic [15:0]                         speedLimit,
   output logic                                refPulseOut,
   output logic                                positionDoneOutput
);

   if (SAMPLE_CYC < 1 || SAMPLE_CYC + 4 > contact_mode_pkg::MAX_LATENCY_CYC) begin : g_badSample
      $error("SAMPLE_CYC breaks the contact latency bound");
   end
   if (RAMP_CYC < 1 || RAMP_CYC > contact_mode_pkg::MAX_LATENCY_CYC) begin : g_badRamp
      $error("RAMP_CYC out of range");
   end

   localparam int CW = contact_mode_pkg::CNT_W;

   // two-flop synchronisers for all pins
   logic [3:0] pinRaw;
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   assign pinRaw = {refPulsePin, speedSelectSecond_n, speedSelectFirst_n,
                    directionChangeoverContact_n};

   for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            // reset to the idle level so no contact looks ON right after reset
            sync1_q[i] <= contact_mode_pkg::PIN_IDLE[i];
            sync2_q[i] <= contact_mode_pkg::PIN_IDLE[i];
         end else begin
            sync1_q[i] <= pinRaw[i];
            sync2_q[i] <= sync1_q[i];
         end
      end
   end

   logic dirOn;
   logic firstOn;
   logic secondOn;
   assign dirOn    = ~sync2_q[0];
   assign firstOn  = ~sync2_q[1];
   assign secondOn = ~sync2_q[2];

   // tick dividers
   logic [CW-1:0] sampleCnt_q;
   logic [CW-1:0] rampCnt_q;
   logic          sampleTick_q;
   logic          rampTick_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sampleCnt_q  <= '0;
         sampleTick_q <= 1'b0;
      end else if (sampleCnt_q == CW'(SAMPLE_CYC - 1)) begin
         sampleCnt_q  <= '0;
         sampleTick_q <= 1'b1;
      end else begin
         sampleCnt_q  <= sampleCnt_q + 1'b1;
         sampleTick_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rampCnt_q  <= '0;
         rampTick_q <= 1'b0;
      end else if (rampCnt_q == CW'(RAMP_CYC - 1)) begin
         rampCnt_q  <= '0;
         rampTick_q <= 1'b1;
      end else begin
         rampCnt_q  <= rampCnt_q + 1'b1;
         rampTick_q <= 1'b0;
      end
   end

   // select contacts are read on the sample tick for speed selection (torque limits take them every clock); soft start plays no part here
   logic selFirst_q;
   logic selSecond_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         selFirst_q  <= 1'b0;
         selSecond_q <= 1'b0;
      end else if (sampleTick_q) begin
         selFirst_q  <= firstOn;  // [R12]
         selSecond_q <= secondOn; // [R12]
      end
   end

   // mode decode
   logic                         contactSpeed;
   logic                         bitA;
   logic                         bitB;
   logic                         bitF;
   contact_mode_pkg::mode_t      mode_d;
   contact_mode_pkg::tref_role_t role_d;
   logic [15:0]                  preset;
   logic signed [15:0]           target;
   logic                         reverse_d;
   logic                         prop_d;
   logic                         clamp_d;
   logic                         soft_d;
   logic [15:0]                  limit_d;

   assign contactSpeed = cfg.functionSwitchWordB[contact_mode_pkg::BIT_CONTACT_SPD];
   assign bitA         = cfg.functionSwitchWordA[contact_mode_pkg::BIT_MODE_A];
   assign bitB         = cfg.functionSwitchWordA[contact_mode_pkg::BIT_MODE_B];
   assign bitF         = cfg.functionSwitchWordA[contact_mode_pkg::BIT_PULSE_F];

   always_comb begin
      mode_d = contact_mode_pkg::MODE_STOP_ZERO;
      preset = 16'h0000;
      if (contactSpeed) begin
         if (selFirst_q || selSecond_q) begin
            mode_d = contact_mode_pkg::MODE_PRESET;
            if (!selFirst_q) begin
               preset = spd.presetSpeedOne;   // [R1]
            end else if (selSecond_q) begin
               preset = spd.presetSpeedTwo;   // [R1]
            end else begin
               preset = spd.presetSpeedThree; // [R1]
            end
         end else if (cfg.isPosition) begin
            // only bit F matters on this row
            mode_d = bitF ? contact_mode_pkg::MODE_PULSE
                          : contact_mode_pkg::MODE_STOP_ZERO; // [R3] [R5] [R20]
         end else begin
            case ({bitB, bitA}) // [R2] [R5]
               2'b00: mode_d = contact_mode_pkg::MODE_STOP_ZERO;
               2'b01: mode_d = contact_mode_pkg::MODE_STOP_CLAMP;
               2'b10: mode_d = contact_mode_pkg::MODE_ANALOG;
               default: mode_d = contact_mode_pkg::MODE_ANALOG_CLAMP;
            endcase
         end
      end else if (cfg.isPosition) begin
         mode_d = contact_mode_pkg::MODE_PULSE; // [R20]
      end else begin
         case ({bitB, bitA})
            2'b10: mode_d = contact_mode_pkg::MODE_TORQUE_I; // [R13]
            2'b11: mode_d = dirOn ? contact_mode_pkg::MODE_TORQUE_II_S
                                  : contact_mode_pkg::MODE_TORQUE_II_T; // [R14]
            default: mode_d = contact_mode_pkg::MODE_SPEED_STD;
         endcase
      end
   end

   always_comb begin
      reverse_d = contactSpeed && dirOn; // [R4] [R18]
      prop_d    = !contactSpeed && dirOn && (cfg.isPosition || {bitB, bitA} == 2'b00); // [R8]
      clamp_d   = (mode_d == contact_mode_pkg::MODE_STOP_CLAMP) ||
                  (mode_d == contact_mode_pkg::MODE_ANALOG_CLAMP) ||
                  (!contactSpeed && !cfg.isPosition && dirOn && {bitB, bitA} == 2'b01); // [R8]
      // pulse following must track the host directly, so no ramp there
      soft_d    = !cfg.isPosition || (contactSpeed && mode_d != contact_mode_pkg::MODE_PULSE); // [R9]
      role_d    = contact_mode_pkg::TREF_UNUSED;
      limit_d   = spd.maxSpeedLimitSetting; // [R13]
      target    = 16'sh0000;
      case (mode_d)
         contact_mode_pkg::MODE_PRESET: begin
            target = reverse_d ? -$signed({1'b0, preset[14:0]})
                               : $signed({1'b0, preset[14:0]});
         end
         contact_mode_pkg::MODE_ANALOG, contact_mode_pkg::MODE_ANALOG_CLAMP,
         contact_mode_pkg::MODE_SPEED_STD: begin
            target = speedRefIn; // [R2]
         end
         contact_mode_pkg::MODE_TORQUE_I: begin
            role_d = contact_mode_pkg::TREF_TORQUE; // [R13]
         end
         contact_mode_pkg::MODE_TORQUE_II_T: begin
            role_d  = contact_mode_pkg::TREF_TORQUE; // [R15]
            limit_d = speedRefIn[15] ? 16'h0000 : speedRefIn; // [R16]
         end
         contact_mode_pkg::MODE_TORQUE_II_S: begin
            target = speedRefIn;
            role_d = cfg.functionSwitchWordB[contact_mode_pkg::BIT_TREF_LIMIT]
                     ? contact_mode_pkg::TREF_LIMIT : contact_mode_pkg::TREF_FEEDFWD; // [R15]
         end
         default: target = 16'sh0000;
      endcase
      if (clamp_d && mode_d == contact_mode_pkg::MODE_SPEED_STD) begin
         target = 16'sh0000;
      end
   end

   // registered mode and status outputs
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         activeMode         <= contact_mode_pkg::MODE_STOP_ZERO;
         torqueRefRole      <= contact_mode_pkg::TREF_UNUSED;
         reverseRotation    <= 1'b0;
         propControl        <= 1'b0;
         zeroClamp          <= 1'b0;
         torqueLimitFwd     <= 1'b0;
         torqueLimitRev     <= 1'b0;
         pulseInhibitEnable <= 1'b0;
         softStartOn        <= 1'b0;
         speedLimit         <= 16'h0000;
         positionDoneOutput <= 1'b0;
      end else begin
         activeMode         <= mode_d;
         torqueRefRole      <= role_d;
         reverseRotation    <= reverse_d;
         propControl        <= prop_d;
         zeroClamp          <= clamp_d;
         torqueLimitFwd     <= !contactSpeed && firstOn;  // [R7]
         torqueLimitRev     <= !contactSpeed && secondOn; // [R7]
         pulseInhibitEnable <= !contactSpeed && cfg.isPosition; // [R6]
         softStartOn        <= soft_d;
         speedLimit         <= limit_d;
         positionDoneOutput <= positionDone;
      end
   end

   // soft-start ramp of the internal speed reference
   logic signed [16:0] diff;
   logic signed [16:0] step;
   logic               away;
   assign diff = {target[15], target} - {speedCmd[15], speedCmd};
   assign away = (diff > 0 && !speedCmd[15]) || (diff < 0 && (speedCmd[15] || speedCmd == 0));
   assign step = away ? $signed({1'b0, spd.accelStep}) : $signed({1'b0, spd.decelStep});

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         speedCmd <= 16'sh0000;
      end else if (!soft_d) begin
         speedCmd <= target;
      end else if (rampTick_q) begin
         if (diff > step) begin
            speedCmd <= 16'(speedCmd + step); // [R19]
         end else if (diff < -step) begin
            speedCmd <= 16'(speedCmd - step); // [R19]
         end else begin
            speedCmd <= target;
         end
      end
   end

   // overspeed turns into opposing torque; the trade is a soft, load-dependent limit
   logic signed [16:0] absAct;
   logic signed [17:0] excess;
   logic signed [17:0] fb;
   logic signed [17:0] torqueSum;
   assign absAct    = actualSpeed[15] ? -{actualSpeed[15], actualSpeed}
                                      : {actualSpeed[15], actualSpeed};
   assign excess    = {absAct[16], absAct} - $signed({2'b00, limit_d});
   assign fb        = (excess > 0) ? (excess >>> feedbackShift) : 18'sh00000;
   assign torqueSum = actualSpeed[15] ? {{2{torqueRefIn[15]}}, torqueRefIn} + fb
                                      : {{2{torqueRefIn[15]}}, torqueRefIn} - fb;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         torqueCmd <= 16'sh0000;
      end else if (role_d == contact_mode_pkg::TREF_TORQUE) begin
         if (torqueSum > 18'sh07FFF) begin
            torqueCmd <= 16'sh7FFF; // [R17]
         end else if (torqueSum < -18'sh08000) begin
            torqueCmd <= -16'sh8000; // [R17]
         end else begin
            torqueCmd <= torqueSum[15:0]; // [R17]
         end
      end else if (role_d != contact_mode_pkg::TREF_UNUSED) begin
         torqueCmd <= torqueRefIn; // [R15]
      end else begin
         torqueCmd <= 16'sh0000;
      end
   end

   // pulse gate after a running preset hands over to pulse following
   logic pulseBlock_q;
   logic pulsePrev_q;
   logic pulseRise;
   logic blockSet;
   assign pulseRise = sync2_q[3] && !pulsePrev_q;
   assign blockSet  = activeMode == contact_mode_pkg::MODE_PRESET &&
                      mode_d == contact_mode_pkg::MODE_PULSE && speedCmd != 0;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pulseBlock_q <= 1'b0;
      end else if (blockSet) begin
         pulseBlock_q <= 1'b1; // [R10]
      end else if (positionDone) begin
         pulseBlock_q <= 1'b0; // [R10] [R11]
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pulsePrev_q <= 1'b0;
         refPulseOut <= 1'b0;
      end else begin
         pulsePrev_q <= sync2_q[3];
         refPulseOut <= pulseRise && !pulseBlock_q && !blockSet &&
                        mode_d == contact_mode_pkg::MODE_PULSE; // [R10]
      end
   end

   // staleness of the sampled select contact, helper for the latency check
   logic [CW-1:0] staleCnt_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         staleCnt_q <= '0;
      end else if (selFirst_q != firstOn) begin
         staleCnt_q <= staleCnt_q + 1'b1;
      end else begin
         staleCnt_q <= '0;
      end
   end

   AST_SAMPLE_LATENCY: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12]
      staleCnt_q <= CW'(SAMPLE_CYC + 1))
      else $error("select contact not sampled in time");

   AST_REVERSE_ONLY_CONTACT: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R4]
      reverseRotation |-> $past(contactSpeed) && $past(dirOn))
      else $error("reverse without contact speed and direction contact");

   AST_TORQUE_LIMIT_INPUT: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
      $past(!contactSpeed && firstOn) |-> torqueLimitFwd)
      else $error("forward torque limit not taken from first contact");

   AST_INHIBIT_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
      $past(contactSpeed) |-> !pulseInhibitEnable)
      else $error("pulse inhibit allowed in contact speed control");

   AST_NO_RAMP_ON_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R9]
      (activeMode == contact_mode_pkg::MODE_PULSE) |-> !softStartOn)
      else $error("soft start active while following pulses");

   AST_PULSE_DROPPED: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
      pulseBlock_q && !positionDone |=> !refPulseOut)
      else $error("pulse passed before positioning complete");

   AST_TORQUE_I_LIMIT: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R13]
      (activeMode == contact_mode_pkg::MODE_TORQUE_I) |->
         speedLimit == $past(spd.maxSpeedLimitSetting))
      else $error("torque control one limit is not the max setting");

   AST_CHANGEOVER: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R14]
      (activeMode == contact_mode_pkg::MODE_TORQUE_II_S) |-> $past(dirOn))
      else $error("speed sub-mode without changeover contact");

   AST_NO_FEEDBACK_IN_RANGE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R17]
      (role_d == contact_mode_pkg::TREF_TORQUE && excess <= 0) |=>
         torqueCmd == $past(torqueRefIn))
      else $error("torque altered while speed within limit");

   AST_RAMP_ON_TICK: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R19]
      soft_d && $past(soft_d) && !rampTick_q |=> $stable(speedCmd))
      else $error("speed reference moved between ramp ticks");

endmodule // contact_speed_torque_mode_select

/* File: tb/host_pulse_model.sv */
// host controller model issuing reference pulse bursts
`timescale 1ns/100ps
module host_pulse_model (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // burst request and positioning feedback
   input  wire logic sendReq,
   input  wire logic ignoreDone,
   input  wire logic doneSeen,
   // pulse pin
   output logic      refPulsePin
);
   logic [3:0] phase;
   // three pulses, two cycles high and two low; ignoreDone is a deliberate misuse
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase       <= 4'h0;
         refPulsePin <= 1'b0;
      end else if (phase != 4'h0) begin
         phase       <= phase - 4'h1;
         refPulsePin <= phase[1];
      end else if (sendReq && (doneSeen || ignoreDone)) begin
         phase <= 4'hC;
      end
   end
endmodule // host_pulse_model

/* File: tb/tb_top.sv */
// bench for the contact speed and torque mode selector
`timescale 1ns/100ps
module tb_top;
   localparam int SC = 8;
   typedef struct packed {
      logic [7:0]  in;
      logic [3:0]  mode;
      logic [4:0]  fl;
      logic        ck;
      logic [15:0] spd;
   } row_t;
   // in: position, contact speed, B, A, F, direction, first, second (1 = ON)
   // fl: reverse, proportional, clamp, limit fwd, limit rev
   row_t rows [16] = '{
      '{8'h48, 4'h0, 5'h00, 1'b1, 16'h0000}, '{8'h50, 4'h1, 5'h04, 1'b1, 16'h0000},
      '{8'h60, 4'h2, 5'h00, 1'b1, 16'h0123}, '{8'h70, 4'h3, 5'h04, 1'b1, 16'h0123},
      '{8'h41, 4'h4, 5'h00, 1'b1, 16'h0100}, '{8'h47, 4'h4, 5'h10, 1'b1, 16'hFE00},
      '{8'h7A, 4'h4, 5'h00, 1'b1, 16'h0300}, '{8'hF0, 4'h0, 5'h00, 1'b1, 16'h0000},
      '{8'hC8, 4'h5, 5'h00, 1'b0, 16'h0000}, '{8'hC5, 4'h4, 5'h10, 1'b1, 16'hFF00},
      '{8'h06, 4'h6, 5'h0A, 1'b1, 16'h0123}, '{8'h15, 4'h6, 5'h05, 1'b1, 16'h0000},
      '{8'h27, 4'h7, 5'h03, 1'b0, 16'h0000}, '{8'h30, 4'h8, 5'h00, 1'b0, 16'h0000},
      '{8'h34, 4'h9, 5'h00, 1'b1, 16'h0123}, '{8'h84, 4'h5, 5'h08, 1'b1, 16'h0000}};
   contact_mode_pkg::cfg_t       cfg;
   contact_mode_pkg::speeds_t    spd;
   contact_mode_pkg::mode_t      activeMode;
   contact_mode_pkg::tref_role_t torqueRefRole;
   logic ref_clk = 1'b0, rst_n = 1'b0, dir_n, first_n, second_n, refPulsePin;
   logic positionDone = 1'b0, sendReq = 1'b0, ignoreDone = 1'b0;
   logic [3:0] feedbackShift = 4'h2;
   logic signed [15:0] speedRefIn = 16'h0123, torqueRefIn = 16'h01F4, actualSpeed = 16'h0000;
   logic reverseRotation, propControl, zeroClamp, torqueLimitFwd, torqueLimitRev;
   logic pulseInhibitEnable, softStartOn, refPulseOut, positionDoneOutput;
   logic signed [15:0] speedCmd, torqueCmd;
   logic [15:0] speedLimit;
   int err_total = 0, n_compared = 0, pulseCnt = 0, k;

   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (refPulseOut === 1'b1) pulseCnt++;

   contact_speed_torque_mode_select #(.SAMPLE_CYC(SC), .RAMP_CYC(4)) DUT (
      .ref_clk, .rst_n, .cfg, .spd, .feedbackShift,
      .directionChangeoverContact_n(dir_n), .speedSelectFirst_n(first_n),
      .speedSelectSecond_n(second_n), .refPulsePin, .speedRefIn, .torqueRefIn,
      .actualSpeed, .positionDone, .activeMode, .torqueRefRole, .reverseRotation,
      .propControl, .zeroClamp, .torqueLimitFwd, .torqueLimitRev, .pulseInhibitEnable,
      .softStartOn, .speedCmd, .torqueCmd, .speedLimit, .refPulseOut, .positionDoneOutput);
   host_pulse_model HOST (.ref_clk, .rst_n, .sendReq, .ignoreDone,
      .doneSeen(positionDoneOutput), .refPulsePin);

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic setRow(input logic [7:0] v, input logic b15);
      cfg = '{v[7], {b15, 12'h000, v[6], 2'h0}, {v[3], 3'h0, v[5], v[4], 10'h000}};
      dir_n = !v[2];
      first_n = !v[1];
      second_n = !v[0];
   endtask
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      #(25 * 4000);
      err_total++;
      wrap_up();
   end

   initial begin
      setRow(8'h40, 1'b0);
      spd = '{16'h0100, 16'h0200, 16'h0300, 16'h03E8, 16'h7FFF, 16'h7FFF};
      cyc(8);
      rst_n = 1'b1;
      cyc(2);
      foreach (rows[i]) begin
         setRow(rows[i].in, 1'b0);
         cyc(SC + 20);
         chk({7'h00, activeMode, reverseRotation, propControl, zeroClamp, torqueLimitFwd,
            torqueLimitRev}, {7'h00, rows[i].mode, rows[i].fl});
         if (rows[i].ck) chk(speedCmd, rows[i].spd);
         chk({15'h0000, pulseInhibitEnable}, {15'h0000, rows[i].in[7] & !rows[i].in[6]});
      end
      // overspeed of 64 at shift 2 trims 16 from the torque input
      setRow(8'h20, 1'b0);
      actualSpeed = 16'h0428;
      cyc(4);
      chk(speedLimit, 16'h03E8);
      chk(torqueCmd, 16'h01E4);
      chk({14'h0000, torqueRefRole}, 16'h0001);
      actualSpeed = 16'h0000;
      setRow(8'h30, 1'b0);
      speedRefIn = 16'hFF00;
      cyc(4);
      chk(speedLimit, 16'h0000);
      speedRefIn = 16'h0123;
      cyc(4);
      chk(speedLimit, 16'h0123);
      chk(torqueCmd, 16'h01F4);
      for (k = 0; k < 2; k++) begin
         setRow(8'h34, k[0]);
         cyc(6);
         chk({14'h0000, torqueRefRole}, k ? 16'h0003 : 16'h0002);
         chk(torqueCmd, 16'h01F4);
      end
      // small step so the first ramp tick is visible
      setRow(8'h40, 1'b0);
      cyc(SC + 20);
      spd.accelStep = 16'h0040;
      second_n = 1'b0;
      k = 0;
      while (speedCmd === 16'h0000 && k < 60) begin
         cyc(1);
         k++;
      end
      chk(speedCmd, 16'h0040);
      cyc(24);
      chk(speedCmd, 16'h0100);
      chk({15'h0000, softStartOn}, 16'h0001);
      // position type: run preset one, then hand over to pulses
      setRow(8'hC8, 1'b0);
      cyc(SC + 20);
      second_n = 1'b0;
      k = 0;
      while (activeMode !== contact_mode_pkg::MODE_PRESET && k < 40) begin
         cyc(1);
         k++;
      end
      chk(16'(k <= SC + 4), 16'h0001);
      cyc(8);
      second_n = 1'b1;
      cyc(SC + 8);
      chk({15'h0000, softStartOn}, 16'h0000);
      ignoreDone = 1'b1;
      sendReq = 1'b1;
      cyc(1);
      sendReq = 1'b0;
      cyc(20);
      chk(16'(pulseCnt), 16'h0000);
      positionDone = 1'b1;
      cyc(2);
      chk({15'h0000, positionDoneOutput}, 16'h0001);
      ignoreDone = 1'b0;
      sendReq = 1'b1;
      cyc(1);
      sendReq = 1'b0;
      cyc(20);
      chk(16'(pulseCnt), 16'h0003);
      // second reset in mid-run clears the decode
      rst_n = 1'b0;
      cyc(1);
      chk({12'h000, activeMode}, 16'h0000);
      chk(speedCmd, 16'h0000);
      rst_n = 1'b1;
      cyc(SC + 20);
      chk({12'h000, activeMode}, 16'h0005);
      wrap_up();
   end
endmodule // tb_top
